// file: dv/dsps_ctrl_checker.sv
// Port checker of the phase sequencer controller
`timescale 1ns/1ns
module dsps_ctrl_checker (
    input wire        core_clk,
    input wire        rst_n,
    input wire        wb_cyc_i,
    input wire        wb_stb_i,
    input wire        wb_we_i,
    input wire [3:0]  wb_adr_i,
    input wire [3:0]  wb_sel_i,
    input wire [31:0] wb_dat_i,
    input wire [31:0] wb_dat_o,
    input wire        wb_ack_o,
    input wire [1:0]  step_code_pair,
    input wire        chn_sel_hi,
    input wire        chn_sel_lo,
    input wire        zero_cross_flag
);
    // ----
    // Assertions
    // ----
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rst_n);
    ph_order_a: assert property ($changed(step_code_pair) |-> step_code_pair == $past(step_code_pair) + 2'h1)
        else $error("phase order broken");
    idle_rst_a: assert property ($rose(rst_n) |-> step_code_pair == 2'h1)
        else $error("not idle after reset");
    ack_resp_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
        else $error("ack missing");
    ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack too long");
    chn_hold_a: assert property (step_code_pair != 2'h1 |-> $stable({chn_sel_hi, chn_sel_lo}))
        else $error("channel moved mid conversion");
    int_hold_a: assert property ($rose(step_code_pair == 2'h2) |-> (step_code_pair == 2'h2)[*3])
        else $error("integrate cut short");
    deint_end_a: assert property ((step_code_pair == 2'h3 && !zero_cross_flag)[*6] |=> step_code_pair != 2'h3)
        else $error("de-integrate not ended");
    clear_exit_a: assert property ((step_code_pair == 2'h0 && zero_cross_flag)[*6] |=> step_code_pair == 2'h1)
        else $error("clear not ended");
    unmapped_rd_a: assert property (wb_ack_o && !wb_we_i && wb_adr_i == 4'h6 |-> wb_dat_o == 32'h0)
        else $error("unmapped read not zero");
    cover property (step_code_pair == 2'h3 ##1 step_code_pair == 2'h0);
    cover property (wb_ack_o && wb_we_i);
    cover property (chn_sel_hi && chn_sel_lo && step_code_pair == 2'h2);
endmodule

// file: dv/dsps_fe_model.sv
// Behavioural front end: integrator, comparator and channel mux
`timescale 1ns/1ns
`include "dsps_regs.vh"
module dsps_fe_model #(
    parameter DLY = `DSPS_CMP_DLY_CYC,
    parameter R   = 8
) (
    input  wire        core_clk,
    input  wire [1:0]  step_code_pair,
    input  wire        chn_sel_hi,
    input  wire        chn_sel_lo,
    input  wire [63:0] vins,
    output reg         zero_cross_flag
);
    // ----
    // Integrator, follows the codes unlatched
    // ----
    integer            acc = 0;
    integer            cnt = 0;
    reg                pos = 1'b0;
    reg                tgl = 1'b0;
    wire [1:0]         ch  = {chn_sel_hi, chn_sel_lo};
    wire signed [15:0] v   = vins[16*ch +: 16];
    always @(posedge core_clk) begin
        case (step_code_pair)
            2'h1: begin
                acc <= 0;
                cnt <= 0;
                tgl <= ~tgl;
            end
            2'h2: begin
                acc <= acc + v;
                pos <= acc + v > 0;
            end
            2'h3: begin
                acc <= pos ? acc - R : acc + R;
                cnt <= (pos ? acc > 0 : acc < 0) ? 0 : cnt + 1;
            end
            default: acc <= acc > R ? acc - R : acc < -R ? acc + R : 0;
        endcase
    end
    // Toggles in null so a design that trusts it there goes wrong
    always @* begin
        case (step_code_pair)
            2'h1: zero_cross_flag = tgl;
            2'h2: zero_cross_flag = acc > 0;
            2'h3: zero_cross_flag = cnt < DLY;
            default: zero_cross_flag = acc == 0;
        endcase
    end
endmodule

// file: dv/dual_slope_phase_sequencer_bench.sv
// Self-checking bench of the phase sequencer controller
`timescale 1ns/1ns
`include "dsps_regs.vh"
`define CHK(a, e) begin checks++; if ((a) !== (e)) begin n_errors++; $display("[ERR] %0t got %h exp %h", $time, a, e); end end
module dual_slope_phase_sequencer_bench;
    // ----
    // Signals
    // ----
    localparam int INTL = 200;
    localparam int DLY  = `DSPS_CMP_DLY_CYC;
    localparam int R    = 8;
    logic        core_clk = 1'b0;
    logic        rst_n    = 1'b0;
    logic        wb_cyc_i = 1'b0;
    logic        wb_stb_i = 1'b0;
    logic        wb_we_i  = 1'b0;
    logic [3:0]  wb_adr_i = 4'h0;
    logic [3:0]  wb_sel_i = 4'hf;
    logic [31:0] wb_dat_i = 32'h0;
    logic [63:0] vins     = 64'h0;
    logic [31:0] lf       = 32'h052cf87b;
    logic [31:0] q;
    logic [31:0] wb_dat_o;
    logic        wb_ack_o;
    logic [1:0]  step_code_pair;
    logic        chn_sel_hi;
    logic        chn_sel_lo;
    logic        zero_cross_flag;
    int          n_errors = 0;
    int          checks   = 0;
    int          cyc_n    = 0;
    int          v;
    dsps_ctrl i_dsps_ctrl (.core_clk(core_clk), .rst_n(rst_n), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
        .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
        .wb_ack_o(wb_ack_o), .step_code_pair(step_code_pair), .chn_sel_hi(chn_sel_hi), .chn_sel_lo(chn_sel_lo),
        .zero_cross_flag(zero_cross_flag));
    dsps_fe_model #(.DLY(DLY), .R(R)) i_dsps_fe_model (.core_clk(core_clk), .step_code_pair(step_code_pair),
        .chn_sel_hi(chn_sel_hi), .chn_sel_lo(chn_sel_lo), .vins(vins), .zero_cross_flag(zero_cross_flag));
    initial forever #10 core_clk = ~core_clk;
    always @(posedge core_clk) begin
        cyc_n++;
        if (cyc_n == 20000) begin
            n_errors++;
            end_of_test;
        end
    end
    // ----
    // Tasks
    // ----
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    task automatic end_of_test;
        if (n_errors == 0 && checks > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    task automatic wb(input logic we, input logic [3:0] a, input logic [31:0] d, output logic [31:0] r);
        int n;
        n = 0;
        @(posedge core_clk);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i  <= we;
        wb_adr_i <= a;
        wb_dat_i <= d;
        do begin
            @(posedge core_clk);
            n++;
        end while (wb_ack_o !== 1'b1 && n < 50);
        r = wb_dat_o;
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
    endtask
    // Runs one conversion; a second start and an INT write while busy must be ignored
    task automatic conv(input logic [1:0] ch, input int s);
        int k, e, n;
        logic o;
        k = ((s < 0 ? -s : s) * (INTL + 1) + R - 1) / R;
        e = k + DLY + 3;
        o = e > 2 * INTL;
        vins[16*ch +: 16] <= s[15:0];
        wb(1'b1, `DSPS_CTRL_OFS, {26'h0, ch, 4'h1}, q);
        wb(1'b1, `DSPS_CTRL_OFS, {26'h0, ~ch, 4'h1}, q);
        wb(1'b1, `DSPS_INT_OFS, 32'd50, q);
        n = 0;
        q = 32'h0;
        while (q[1] !== 1'b1 && n < 3000) begin
            wb(1'b0, `DSPS_STATUS_OFS, 32'h0, q);
            n++;
        end
        `CHK(q[0], 1'b0)
        `CHK(q[2], o)
        `CHK(q[3], s < 0)
        `CHK(q[5:4], 2'h1)
        `CHK({chn_sel_hi, chn_sel_lo}, ch)
        wb(1'b0, `DSPS_RESULT_OFS, 32'h0, q);
        `CHK(q[31], s < 0)
        if (!o) `CHK(q[24:0] >= e - 5 && q[24:0] <= e + 5, 1'b1)
    endtask
    // ----
    // Sequence
    // ----
    initial begin
        repeat (2) @(posedge core_clk);
        rst_n <= 1'b1;
        @(posedge core_clk);
        `CHK(step_code_pair, 2'h1)
        `CHK({chn_sel_hi, chn_sel_lo}, 2'h0)
        wb(1'b0, `DSPS_INT_OFS, 32'h0, q);
        `CHK(q[23:0], `DSPS_INT_RST)
        wb(1'b0, 4'h6, 32'h0, q);
        `CHK(q, 32'h0)
        wb(1'b1, `DSPS_INT_OFS, INTL, q);
        for (int c = 0; c < 4; c++) begin
            lf = lfsr(lf);
            v = lf[2:0] + 1;
            if (lf[3]) v = -v;
            conv(c[1:0], v);
        end
        conv(2'h1, 15);
        conv(2'h2, -15);
        wb(1'b0, `DSPS_INT_OFS, 32'h0, q);
        `CHK(q[23:0], 24'd200)
        end_of_test;
    end
endmodule
bind dsps_ctrl dsps_ctrl_checker i_dsps_ctrl_checker (.core_clk(core_clk), .rst_n(rst_n), .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
    .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .step_code_pair(step_code_pair), .chn_sel_hi(chn_sel_hi),
    .chn_sel_lo(chn_sel_lo), .zero_cross_flag(zero_cross_flag));

// file: hw/dsps_ctrl.v
// Host controller that sequences the dual-slope front end and times de-integration
//
// Contract
// - Drive one of four phase codes always
// - Order: null, integrate, de-integrate, clear
// - Hold comparator level near integrate end
// - Sample polarity just before 10 to 11
// - Stored polarity is result sign bit
// - Ignore comparator during offset null
// - Integration a whole mains period multiple (reset length 24'h325aa0 is 66 ms at 50 MHz, not a whole period at 50 or 60 Hz)
// - Integration duration same every conversion
// - De-integrate immediately, end at crossing
// - De-integrate limit twice integration count
// - Count from 10 to 11 until fall
// - Clear until comparator high, stop at once
// - Then hold offset null until next
// - Offset null is the idle state
// - Offset null duration equals integration duration
// - Outputs drive phase, input watches comparator
// - Two active-high channel selects, 00 first
//
// Our own choices: the register addresses and the Wishbone register port.
`timescale 1ns/1ns
`include "dsps_regs.vh"
module dsps_ctrl (
    // Clock and reset
    input  wire        core_clk,
    input  wire        rst_n,
    // Wishbone slave
    input  wire        wb_cyc_i,
    input  wire        wb_stb_i,
    input  wire        wb_we_i,
    input  wire [3:0]  wb_adr_i,
    input  wire [3:0]  wb_sel_i,
    input  wire [31:0] wb_dat_i,
    output reg  [31:0] wb_dat_o,
    output reg         wb_ack_o,
    // Front end pins
    output reg  [1:0]  step_code_pair,
    output reg         chn_sel_hi,
    output reg         chn_sel_lo,
    input  wire        zero_cross_flag
);
    // ----------------------------------------------------------------
    // States
    // ----------------------------------------------------------------
    localparam [2:0] ST_IDLE  = 3'h0;
    localparam [2:0] ST_NULL  = 3'h1;
    localparam [2:0] ST_INT   = 3'h2;
    localparam [2:0] ST_DEINT = 3'h3;
    localparam [2:0] ST_CLEAR = 3'h4;
    localparam [2:0] ST_HOLD  = 3'h5;

    reg [2:0]  state_reg;
    reg [23:0] int_len_reg;
    reg [23:0] run_len_reg;
    reg [24:0] cnt_reg;
    reg [24:0] mag_reg;
    reg        sign_reg;
    reg        ovr_reg;
    reg        done_reg;
    reg        start_reg;
    reg [1:0]  chn_reg;
    reg [5:0]  div_reg;
    reg        tick_reg;

    wire cmp_lvl;
    wire cmp_fall;
    wire cmp_rise;

    // ----------------------------------------------------------------
    // Comparator synchroniser
    // ----------------------------------------------------------------
    dsps_sync u_sync (
        .core_clk (core_clk),
        .rst_n    (rst_n),
        .din      (zero_cross_flag),
        .dout     (cmp_lvl),
        .fall     (cmp_fall),
        .rise     (cmp_rise)
    );

    // Count end test shared by the timed phases
    function cnt_hit;
        input [24:0] cnt;
        input [24:0] lim;
        begin
            cnt_hit = (cnt >= lim);
        end
    endfunction

    // ----------------------------------------------------------------
    // Count tick divider
    // ----------------------------------------------------------------
    // Default divide of one keeps full 20 ns resolution per count
    always @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            div_reg  <= 6'h00;
            tick_reg <= 1'b0;
        end else if (div_reg >= `DSPS_TICK_DIV - 6'h01) begin
            div_reg  <= 6'h00;
            tick_reg <= 1'b1;
        end else begin
            div_reg  <= div_reg + 6'h01;
            tick_reg <= 1'b0;
        end
    end

    // ----------------------------------------------------------------
    // Wishbone slave, one wait state, ack drops after one cycle
    // ----------------------------------------------------------------
    wire bus_req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
    wire bus_wr  = bus_req & wb_we_i;
    wire busy    = (state_reg != ST_IDLE);

    always @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            wb_ack_o    <= 1'b0;
            wb_dat_o    <= 32'h00000000;
            int_len_reg <= `DSPS_INT_RST;
            chn_reg     <= `DSPS_CTRL_RST;
            start_reg   <= 1'b0;
        end else begin
            wb_ack_o  <= bus_req;
            start_reg <= 1'b0;
            if (bus_wr && wb_adr_i == `DSPS_CTRL_OFS && wb_sel_i[0]) begin
                start_reg <= wb_dat_i[`DSPS_CTRL_START];
                chn_reg   <= wb_dat_i[`DSPS_CTRL_CHN_HI:`DSPS_CTRL_CHN_LO];
            end
            // Length is frozen during a conversion so every run sees the same one
            if (bus_wr && wb_adr_i == `DSPS_INT_OFS && !busy) begin
                if (wb_sel_i[0]) int_len_reg[7:0]   <= wb_dat_i[7:0];
                if (wb_sel_i[1]) int_len_reg[15:8]  <= wb_dat_i[15:8];
                if (wb_sel_i[2]) int_len_reg[23:16] <= wb_dat_i[23:16];
            end
            if (bus_req) begin
                case (wb_adr_i)
                    `DSPS_CTRL_OFS:   wb_dat_o <= {26'h0, chn_reg, 4'h0};
                    `DSPS_INT_OFS:    wb_dat_o <= {8'h00, int_len_reg};
                    `DSPS_STATUS_OFS: wb_dat_o <= {26'h0, step_code_pair, sign_reg, ovr_reg, done_reg, busy};
                    `DSPS_RESULT_OFS: wb_dat_o <= {sign_reg, 6'h00, mag_reg};
                    default:          wb_dat_o <= 32'h00000000;
                endcase
            end
        end
    end

    // ----------------------------------------------------------------
    // Phase sequencer
    // ----------------------------------------------------------------
    // Overshoot during clear is bounded by the sync latency of about 80 ns
    always @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            state_reg      <= ST_IDLE;
            step_code_pair <= `DSPS_PH_NULL;
            chn_sel_hi     <= 1'b0;
            chn_sel_lo     <= 1'b0;
            run_len_reg    <= 24'h000000;
            cnt_reg        <= 25'h0000000;
            mag_reg        <= 25'h0000000;
            sign_reg       <= 1'b0;
            ovr_reg        <= 1'b0;
            done_reg       <= 1'b0;
        end else begin
            // Read of status clears done; a new completion wins
            if (bus_req && !wb_we_i && wb_adr_i == `DSPS_STATUS_OFS)
                done_reg <= 1'b0;
            case (state_reg)
                ST_IDLE: begin
                    step_code_pair <= `DSPS_PH_NULL;
                    if (start_reg) begin
                        chn_sel_hi     <= chn_reg[1];
                        chn_sel_lo     <= chn_reg[0];
                        run_len_reg    <= int_len_reg;
                        cnt_reg        <= 25'h0000000;
                        ovr_reg        <= 1'b0;
                        state_reg      <= ST_NULL;
                    end
                end
                ST_NULL: begin
                    // Comparator ignored here; null time matches integrate time
                    if (tick_reg)
                        cnt_reg <= cnt_reg + 25'h0000001;
                    if (cnt_hit(cnt_reg, {1'b0, run_len_reg})) begin
                        cnt_reg        <= 25'h0000000;
                        step_code_pair <= `DSPS_PH_INT;
                        state_reg      <= ST_INT;
                    end
                end
                ST_INT: begin
                    if (tick_reg)
                        cnt_reg <= cnt_reg + 25'h0000001;
                    // Polarity taken on the last cycle before 10 to 11
                    if (cnt_hit(cnt_reg, {1'b0, run_len_reg})) begin
                        sign_reg       <= ~cmp_lvl;
                        cnt_reg        <= 25'h0000000;
                        step_code_pair <= `DSPS_PH_DEINT;
                        state_reg      <= ST_DEINT;
                    end
                end
                ST_DEINT: begin
                    if (tick_reg)
                        cnt_reg <= cnt_reg + 25'h0000001;
                    // Count still includes the comparator lag; software may subtract it
                    // Level is trusted only once the sync pipe holds de-integrate samples
                    if (cmp_fall || (!cmp_lvl && cnt_hit(cnt_reg, `DSPS_SYNC_LAT))) begin
                        mag_reg        <= cnt_reg;
                        cnt_reg        <= 25'h0000000;
                        step_code_pair <= `DSPS_PH_CLEAR;
                        state_reg      <= ST_CLEAR;
                    end else if (cnt_hit(cnt_reg, {run_len_reg, 1'b0})) begin
                        mag_reg        <= cnt_reg;
                        cnt_reg        <= 25'h0000000;
                        ovr_reg        <= 1'b1;
                        step_code_pair <= `DSPS_PH_CLEAR;
                        state_reg      <= ST_CLEAR;
                    end
                end
                ST_CLEAR: begin
                    // Stale high level from de-integrate is not taken as the end of clear
                    if (!cnt_hit(cnt_reg, `DSPS_SYNC_LAT))
                        cnt_reg <= cnt_reg + 25'h0000001;
                    if (cmp_rise || (cmp_lvl && cnt_hit(cnt_reg, `DSPS_SYNC_LAT))) begin
                        step_code_pair <= `DSPS_PH_NULL;
                        state_reg      <= ST_HOLD;
                    end
                end
                ST_HOLD: begin
                    done_reg  <= 1'b1;
                    state_reg <= ST_IDLE;
                end
                default: begin
                    step_code_pair <= `DSPS_PH_NULL;
                    state_reg      <= ST_IDLE;
                end
            endcase
        end
    end
endmodule

// file: hw/dsps_regs.vh
// Register map and timing constants of the dual-slope phase sequencer controller
`ifndef DSPS_REGS_VH
`define DSPS_REGS_VH

// ----------------------------------------------------------------
// Register offsets (byte addresses)
// ----------------------------------------------------------------
`define DSPS_CTRL_OFS      4'h0
`define DSPS_INT_OFS       4'h4
`define DSPS_STATUS_OFS    4'h8
`define DSPS_RESULT_OFS    4'hc

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define DSPS_CTRL_START    0
`define DSPS_CTRL_CHN_LO   4
`define DSPS_CTRL_CHN_HI   5
`define DSPS_STAT_BUSY     0
`define DSPS_STAT_DONE     1
`define DSPS_STAT_OVR      2
`define DSPS_STAT_SIGN     3
`define DSPS_STAT_PH_LO    4
`define DSPS_STAT_PH_HI    5

// ----------------------------------------------------------------
// Phase codes on the step code pair
// ----------------------------------------------------------------
`define DSPS_PH_CLEAR      2'h0
`define DSPS_PH_NULL       2'h1
`define DSPS_PH_INT        2'h2
`define DSPS_PH_DEINT      2'h3

// ----------------------------------------------------------------
// Reset values and timing
// ----------------------------------------------------------------
`define DSPS_CTRL_RST      2'h0
`define DSPS_INT_RST       24'h325aa0
`define DSPS_CLK_MHZ       50
`define DSPS_CMP_DLY_US    2
`define DSPS_CMP_DLY_CYC   (`DSPS_CMP_DLY_US * `DSPS_CLK_MHZ)
`define DSPS_TICK_DIV      6'h01
`define DSPS_SYNC_LAT      25'h0000004

`endif

// file: hw/dsps_sync.v
// Two-stage synchroniser with falling and rising edge pulses
`timescale 1ns/1ns
module dsps_sync (
    // Clock and reset
    input  wire core_clk,
    input  wire rst_n,
    // Pin side
    input  wire din,
    // Core side
    output reg  dout,
    output reg  fall,
    output reg  rise
);
    reg meta_reg;
    reg sync_reg;

    // Only sync_reg reads meta_reg; edges come from later stages
    always @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            meta_reg <= 1'b0;
            sync_reg <= 1'b0;
            dout     <= 1'b0;
            fall     <= 1'b0;
            rise     <= 1'b0;
        end else begin
            meta_reg <= din;
            sync_reg <= meta_reg;
            dout     <= sync_reg;
            fall     <= dout & ~sync_reg;
            rise     <= ~dout & sync_reg;
        end
    end
endmodule
